/* hdl/vrp_regs.vh */
`ifndef VRP_REGS_VH
`define VRP_REGS_VH

// Register word indices on the Avalon word address
`define VRP_IDX_CTRL        4'h0
`define VRP_IDX_STATUS      4'h1
`define VRP_IDX_V1_RMS      4'h2
`define VRP_IDX_V2_RMS      4'h3
`define VRP_IDX_V1_RMS_OS   4'h4
`define VRP_IDX_V2_RMS_OS   4'h5
`define VRP_IDX_P1_GAIN     4'h6
`define VRP_IDX_P2_GAIN     4'h7
`define VRP_IDX_P1_OS       4'h8
`define VRP_IDX_P2_OS       4'h9
`define VRP_IDX_ACT_POWER   4'hA
`define VRP_IDX_WAVEFORM    4'hB

// Control register fields
`define VRP_CTRL_WIRING     0
`define VRP_CTRL_ZX_EN      1
`define VRP_CTRL_SIGN_DIR   2
`define VRP_CTRL_SIGN_MASK  3
`define VRP_CTRL_WF_MASK    4
`define VRP_CTRL_SMODE_LO   8
`define VRP_CTRL_SMODE_HI   9

// Status register fields
`define VRP_STAT_SIGN_FLAG  0

// Reset values
`define VRP_RST_CTRL        32'h0000_0018
`define VRP_RST_ZERO        32'h0000_0000

// Sample mode code that routes active power to the waveform register
`define VRP_SMODE_POWER     2'h1

// Datapath scaling
`define VRP_PROD_SHIFT      11
`define VRP_LPF_SHIFT       7
`define VRP_GAIN_ONE        14'h1000
`define VRP_CAL_SHIFT       19
`define VRP_RMS_MAX         24'hFFFFFF

`endif

/* hdl/vrp_calc.v */
`timescale 1ns/100ps
`default_nettype none
`include "vrp_regs.vh"

module vrp_calc (
    // Clock and reset
    input  wire        clk_i,
    input  wire        srst_i,
    // Converter sample path
    input  wire        sample_valid_i,
    input  wire [23:0] v1_sample_i,
    input  wire [23:0] i1_sample_i,
    input  wire [23:0] v2_sample_i,
    input  wire [23:0] i2_sample_i,
    input  wire [23:0] v1_rms_raw_i,
    input  wire [23:0] v2_rms_raw_i,
    input  wire        line1_zero_cross_event_i,
    input  wire        line2_zero_cross_event_i,
    // Avalon-MM slave
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // Interrupt request
    output wire        sign_change_interrupt_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    function [31:0] be_merge;
        input [31:0] old_v;
        input [31:0] wd;
        input [3:0]  be;
        integer      k;
        begin
            be_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    be_merge[k*8 +: 8] = wd[k*8 +: 8];
                end
            end
        end
    endfunction

    // Word index match, shared by every write strobe
    function idx_is;
        input [3:0] adr;
        input [3:0] idx;
        begin
            idx_is = (adr == idx);
        end
    endfunction

    // Raw RMS plus sixteen offset LSBs, clamped to the unsigned range
    function [23:0] rms_corr;
        input [23:0] raw;
        input [11:0] os;
        reg signed [25:0] s;
        begin
            s = $signed({2'b00, raw}) + $signed({{10{os[11]}}, os, 4'h0});
            if (s < 26'sd0) begin
                rms_corr = 24'h000000;
            end else if (s[25:24] != 2'b00) begin
                rms_corr = `VRP_RMS_MAX;
            end else begin
                rms_corr = s[23:0];
            end
        end
    endfunction

    // Product in 1/128 filter LSB units, single-pole low-pass step
    function [39:0] lpf_step;
        input [39:0] y;
        input [23:0] v;
        input [23:0] i;
        reg signed [47:0] p;
        reg signed [47:0] ps;
        reg signed [40:0] d;
        reg signed [40:0] ds;
        begin
            p  = $signed(v) * $signed(i);
            ps = p >>> `VRP_PROD_SHIFT;
            d  = $signed({ps[39], ps[39:0]}) - $signed({y[39], y});
            ds = d >>> `VRP_LPF_SHIFT;
            lpf_step = y + ds[39:0];
        end
    endfunction

    // Offset in 1/128 units, then gain, then back to whole filter LSBs
    function [31:0] calib;
        input [39:0] y;
        input [15:0] os;
        input [11:0] g;
        reg signed [40:0] t;
        reg signed [13:0] gm;
        reg signed [54:0] m;
        reg signed [54:0] ms;
        begin
            t  = $signed({y[39], y}) + $signed({{25{os[15]}}, os});
            gm = $signed(`VRP_GAIN_ONE) + $signed({{2{g[11]}}, g});
            m  = t * gm;
            ms = m >>> `VRP_CAL_SHIFT;
            calib = ms[31:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    reg [31:0] ctrl_reg;
    reg        sign_flag_reg;
    reg [23:0] v1_rms_reg;
    reg [23:0] v2_rms_reg;
    reg [11:0] v1_rms_os_reg;
    reg [11:0] v2_rms_os_reg;
    reg [11:0] p1_gain_reg;
    reg [11:0] p2_gain_reg;
    reg [15:0] p1_os_reg;
    reg [15:0] p2_os_reg;
    reg [31:0] power_reg;
    reg [31:0] wave_reg;
    reg [39:0] lpf1_reg;
    reg [39:0] power_lowpass_filter_reg;
    reg        calc_reg;
    reg        sign_prev_reg;
    reg        irq_reg;
    reg        wait_reg;
    reg [31:0] rdata_reg;

    wire       wiring_mode_select       = ctrl_reg[`VRP_CTRL_WIRING];
    wire       zero_cross_update_enable = ctrl_reg[`VRP_CTRL_ZX_EN];
    wire       sign_direction_select    = ctrl_reg[`VRP_CTRL_SIGN_DIR];
    wire       sign_change_mask         = ctrl_reg[`VRP_CTRL_SIGN_MASK];
    wire       waveform_irq_mask        = ctrl_reg[`VRP_CTRL_WF_MASK];
    wire [1:0] sample_mode_select       = ctrl_reg[`VRP_CTRL_SMODE_HI:`VRP_CTRL_SMODE_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire bus_req = avs_read_i | avs_write_i;
    wire wr_hit  = avs_write_i & ~wait_reg;

    reg [31:0] rd_mux;
    always @* begin
        case (avs_address_i)
            `VRP_IDX_CTRL:      rd_mux = ctrl_reg;
            `VRP_IDX_STATUS:    rd_mux = {31'h0, sign_flag_reg};
            `VRP_IDX_V1_RMS:    rd_mux = {8'h00, v1_rms_reg};
            `VRP_IDX_V2_RMS:    rd_mux = {8'h00, v2_rms_reg};
            `VRP_IDX_V1_RMS_OS: rd_mux = {20'h0, v1_rms_os_reg};
            `VRP_IDX_V2_RMS_OS: rd_mux = {20'h0, v2_rms_os_reg};
            `VRP_IDX_P1_GAIN:   rd_mux = {20'h0, p1_gain_reg};
            `VRP_IDX_P2_GAIN:   rd_mux = {20'h0, p2_gain_reg};
            `VRP_IDX_P1_OS:     rd_mux = {16'h0, p1_os_reg};
            `VRP_IDX_P2_OS:     rd_mux = {16'h0, p2_os_reg};
            `VRP_IDX_ACT_POWER: rd_mux = power_reg;
            `VRP_IDX_WAVEFORM:  rd_mux = wave_reg;
            default:            rd_mux = `VRP_RST_ZERO;
        endcase
    end

    // One wait cycle per access; read data latched as waitrequest drops
    always @(posedge clk_i) begin
        if (srst_i) begin
            wait_reg  <= 1'b1;
            rdata_reg <= `VRP_RST_ZERO;
        end else begin
            wait_reg <= ~(bus_req & wait_reg);
            if (avs_read_i & wait_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    wire [31:0] wmerge = be_merge(rd_mux, avs_writedata_i, avs_byteenable_i);

    ////////////////////////////////////////////////////////////////////////////
    // Write strobes, one per writable register

    wire wr_ctrl    = wr_hit & idx_is(avs_address_i, `VRP_IDX_CTRL);
    wire wr_status  = wr_hit & idx_is(avs_address_i, `VRP_IDX_STATUS);
    wire wr_v1_os   = wr_hit & idx_is(avs_address_i, `VRP_IDX_V1_RMS_OS);
    wire wr_v2_os   = wr_hit & idx_is(avs_address_i, `VRP_IDX_V2_RMS_OS);
    wire wr_p1_gain = wr_hit & idx_is(avs_address_i, `VRP_IDX_P1_GAIN);
    wire wr_p2_gain = wr_hit & idx_is(avs_address_i, `VRP_IDX_P2_GAIN);
    wire wr_p1_os   = wr_hit & idx_is(avs_address_i, `VRP_IDX_P1_OS);
    wire wr_p2_os   = wr_hit & idx_is(avs_address_i, `VRP_IDX_P2_OS);

    // Reserved control bits are held at zero
    always @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_reg <= `VRP_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_reg <= {22'h0, wmerge[`VRP_CTRL_SMODE_HI:`VRP_CTRL_SMODE_LO], 3'h0,
                         wmerge[`VRP_CTRL_WF_MASK:`VRP_CTRL_WIRING]};
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            v1_rms_os_reg <= 12'h000;
        end else if (wr_v1_os) begin
            v1_rms_os_reg <= wmerge[11:0];
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            v2_rms_os_reg <= 12'h000;
        end else if (wr_v2_os) begin
            v2_rms_os_reg <= wmerge[11:0];
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            p1_gain_reg <= 12'h000;
        end else if (wr_p1_gain) begin
            p1_gain_reg <= wmerge[11:0];
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            p2_gain_reg <= 12'h000;
        end else if (wr_p2_gain) begin
            p2_gain_reg <= wmerge[11:0];
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            p1_os_reg <= 16'h0000;
        end else if (wr_p1_os) begin
            p1_os_reg <= wmerge[15:0];
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            p2_os_reg <= 16'h0000;
        end else if (wr_p2_os) begin
            p2_os_reg <= wmerge[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Voltage RMS results

    wire v1_upd = zero_cross_update_enable ? line1_zero_cross_event_i
                                           : sample_valid_i;
    wire v2_upd = ~zero_cross_update_enable ? sample_valid_i
                : (wiring_mode_select ? line2_zero_cross_event_i
                                      : line1_zero_cross_event_i);

    // Line 1 result
    always @(posedge clk_i) begin
        if (srst_i) begin
            v1_rms_reg <= 24'h000000;
        end else if (v1_upd) begin
            v1_rms_reg <= rms_corr(v1_rms_raw_i, v1_rms_os_reg);
        end
    end

    // Line 2 result
    always @(posedge clk_i) begin
        if (srst_i) begin
            v2_rms_reg <= 24'h000000;
        end else if (v2_upd) begin
            v2_rms_reg <= rms_corr(v2_rms_raw_i, v2_rms_os_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active power

    wire [31:0] pw1 = calib(lpf1_reg, p1_os_reg, p1_gain_reg);
    wire [31:0] pw2 = calib(power_lowpass_filter_reg, p2_os_reg, p2_gain_reg);
    wire [32:0] pw_sum = {pw1[31], pw1} + {pw2[31], pw2};
    wire [31:0] pw_new = wiring_mode_select ? pw_sum[32:1] : pw1;

    // Sign change against the previous result; zero counts as positive
    wire neg_new  = pw_new[31];
    wire sign_hit = calc_reg & (sign_direction_select ? (sign_prev_reg & ~neg_new)
                                                      : (~sign_prev_reg & neg_new));
    wire flag_clr = wr_status & avs_byteenable_i[0]
                    & ~avs_writedata_i[`VRP_STAT_SIGN_FLAG];

    // Both filter states step on every converter sample
    always @(posedge clk_i) begin
        if (srst_i) begin
            lpf1_reg <= 40'h00_0000_0000;
            power_lowpass_filter_reg <= 40'h00_0000_0000;
        end else if (sample_valid_i) begin
            lpf1_reg <= lpf_step(lpf1_reg, v1_sample_i, i1_sample_i);
            power_lowpass_filter_reg <= lpf_step(power_lowpass_filter_reg, v2_sample_i, i2_sample_i);
        end
    end

    // Result stage runs one edge after the filter step
    always @(posedge clk_i) begin
        if (srst_i) begin
            calc_reg <= 1'b0;
        end else begin
            calc_reg <= sample_valid_i;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            power_reg     <= `VRP_RST_ZERO;
            sign_prev_reg <= 1'b0;
        end else if (calc_reg) begin
            power_reg     <= pw_new;
            sign_prev_reg <= neg_new;
        end
    end

    // Waveform register only follows power when selected and unmasked
    wire wave_load = calc_reg & (sample_mode_select == `VRP_SMODE_POWER)
                     & ~waveform_irq_mask;

    always @(posedge clk_i) begin
        if (srst_i) begin
            wave_reg <= `VRP_RST_ZERO;
        end else if (wave_load) begin
            wave_reg <= pw_new;
        end
    end

    // Set wins over a clear in the same cycle
    always @(posedge clk_i) begin
        if (srst_i) begin
            sign_flag_reg <= 1'b0;
        end else if (sign_hit) begin
            sign_flag_reg <= 1'b1;
        end else if (flag_clr) begin
            sign_flag_reg <= 1'b0;
        end
    end

    // Request follows the flag one edge later
    always @(posedge clk_i) begin
        if (srst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= sign_flag_reg & ~sign_change_mask;
        end
    end

    assign avs_readdata_o          = rdata_reg;
    assign avs_waitrequest_o       = wait_reg;
    assign sign_change_interrupt_o = irq_reg;

endmodule // vrp_calc
`default_nettype wire

/* tb/vrp_calc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module vrp_calc_checker (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        srst_i,
    // Register bus
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // Interrupt
    input wire logic        sign_change_interrupt_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire logic rd_ok = avs_read_i && !avs_waitrequest_o;
    wire logic wr_ok = avs_write_i && !avs_waitrequest_o;
    wire logic irq   = sign_change_interrupt_o;
    property p_ans; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    a_ans: assert property (p_ans) else $error("bus answer missing");
    property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_one: assert property (p_one) else $error("wait low longer than one cycle");
    property p_rst; disable iff (1'b0) srst_i |=> avs_waitrequest_o && !irq; endproperty
    a_rst: assert property (p_rst) else $error("bad outputs in reset");
    property p_unmap; rd_ok && avs_address_i > 4'hB |-> avs_readdata_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rms; rd_ok && avs_address_i inside {4'h2, 4'h3} |-> avs_readdata_o[31:24] == 8'h0; endproperty
    a_rms: assert property (p_rms) else $error("rms wider than 24 bits");
    property p_trim; rd_ok && avs_address_i inside {[4'h4:4'h7]} |-> avs_readdata_o[31:12] == 20'h0; endproperty
    a_trim: assert property (p_trim) else $error("trim wider than 12 bits");
    property p_mask; wr_ok && avs_address_i == 4'h0 && avs_writedata_i[3] |=> ##1 !irq; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt raised");
    property p_hold; irq && !$past(avs_write_i) |=> irq; endproperty
    a_hold: assert property (p_hold) else $error("interrupt dropped by itself");
    c_pwr: cover property (rd_ok && avs_address_i == 4'hA);
    c_irq: cover property ($rose(irq));
    c_clr: cover property (wr_ok && avs_address_i == 4'h1);
endmodule // vrp_calc_checker
bind vrp_calc vrp_calc_checker vrp_calc_checker_i (.clk_i(clk_i), .srst_i(srst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .sign_change_interrupt_o(sign_change_interrupt_o));
`default_nettype wire

/* tb/vrp_adc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module vrp_adc_model #(
    parameter int PERIOD = 6
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Levels to convert
    input  wire logic [23:0] lv_i [4],
    // Sample stream
    output var  logic        valid_o,
    output var  logic [23:0] s_o [4]
);
    int cnt = 0;
    always @(posedge clk_i) begin
        cnt <= (srst_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
        valid_o <= !srst_i && cnt == PERIOD - 1;
        // Samples are scrambled outside the valid cycle
        for (int k = 0; k < 4; k++) begin
            s_o[k] <= (cnt == PERIOD - 1) ? lv_i[k] : ~lv_i[k];
        end
    end
endmodule // vrp_adc_model
`default_nettype wire

/* tb/vrp_calc_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module vrp_calc_tb;
    logic        clk_i  = 1'b0;
    logic        srst_i = 1'b1;
    logic        zx1    = 1'b0;
    logic        zx2    = 1'b0;
    logic        rd     = 1'b0;
    logic        wr     = 1'b0;
    logic [3:0]  adr    = 4'h0;
    logic [31:0] wd     = 32'h0;
    logic [3:0]  be     = 4'hF;
    logic [31:0] q;
    logic [23:0] raw1   = 24'h0;
    logic [23:0] raw2   = 24'h0;
    logic [23:0] lv [4] = '{default: 24'h0};
    wire  logic [23:0] s [4];
    wire  logic [31:0] rdata;
    wire  logic  vld, wt, irq;
    int          err_count = 0;
    int          checks_done = 0;
    // Columns: wiring, gain1, offset1, gain2, offset2, expected power
    logic [31:0] rows [7][6] = '{
        '{32'h0, 32'h000, 32'h0, 32'h000, 32'h0, 32'hFFC00000},
        '{32'h0, 32'h7FF, 32'h0, 32'h800, 32'h0, 32'hFFA00400},
        '{32'h0, 32'h800, 32'h0, 32'h000, 32'h0, 32'hFFE00000},
        '{32'h0, 32'h000, 32'h80, 32'h000, 32'h0, 32'hFFC00001},
        '{32'h1, 32'h000, 32'h0, 32'h000, 32'h0, 32'hFFC00000},
        '{32'h1, 32'h800, 32'h0, 32'h000, 32'h0, 32'hFFD00000},
        '{32'h1, 32'h000, 32'h0, 32'h7FF, 32'h80, 32'hFFB00200}};
    vrp_adc_model vrp_adc_model_i (.clk_i(clk_i), .srst_i(srst_i), .lv_i(lv), .valid_o(vld),
        .s_o(s));
    vrp_calc vrp_calc_i (.clk_i(clk_i), .srst_i(srst_i), .sample_valid_i(vld),
        .v1_sample_i(s[0]), .i1_sample_i(s[1]), .v2_sample_i(s[2]), .i2_sample_i(s[3]),
        .v1_rms_raw_i(raw1), .v2_rms_raw_i(raw2), .line1_zero_cross_event_i(zx1),
        .line2_zero_cross_event_i(zx2), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .sign_change_interrupt_o(irq));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wt !== 1'b0 && n < 40);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n == 40) begin
            chk("bus answer", 32'h0, 32'h1);
            summarize();
        end
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic rms(input logic [31:0] e1, input logic [31:0] e2);
        // Let at least one converter sample pass after the last setting change
        repeat (12) @(posedge clk_i);
        rc(4'h2, e1, "v1 rms");
        rc(4'h3, e2, "v2 rms");
    endtask
    task automatic zx(input int k);
        @(posedge clk_i);
        zx1 <= (k == 1);
        zx2 <= (k == 2);
        @(posedge clk_i);
        zx1 <= 1'b0;
        zx2 <= 1'b0;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            rc(i[3:0], (i == 0) ? 32'h18 : 32'h0, "reset value");
        end
        bus(1'b1, 4'hF, 32'hFFFFFFFF);
        rc(4'hF, 32'h0, "unmapped");
        raw1 <= 24'h100000;
        raw2 <= 24'h0B504F;
        bus(1'b1, 4'h4, 32'hFFF);
        bus(1'b1, 4'h5, 32'h800);
        rms(32'h0FFFF0, 32'h0AD04F);
        bus(1'b1, 4'h0, 32'h1A);
        raw1 <= 24'h200000;
        raw2 <= 24'h300000;
        bus(1'b1, 4'h2, 32'h0);
        rms(32'h0FFFF0, 32'h0AD04F);
        zx(2);
        rms(32'h0FFFF0, 32'h0AD04F);
        zx(1);
        rms(32'h1FFFF0, 32'h2F8000);
        bus(1'b1, 4'h0, 32'h1B);
        raw1 <= 24'h400000;
        raw2 <= 24'h500000;
        zx(1);
        rms(32'h3FFFF0, 32'h2F8000);
        zx(2);
        rms(32'h3FFFF0, 32'h4F8000);
        lv <= '{24'h100000, 24'hF00000, 24'hF00000, 24'h100000};
        repeat (15000) @(posedge clk_i);
        foreach (rows[r]) begin
            bus(1'b1, 4'h0, 32'h108 | rows[r][0]);
            bus(1'b1, 4'h6, rows[r][1]);
            bus(1'b1, 4'h8, rows[r][2]);
            bus(1'b1, 4'h7, rows[r][3]);
            bus(1'b1, 4'h9, rows[r][4]);
            repeat (30) @(posedge clk_i);
            rc(4'hA, rows[r][5], "active power");
            rc(4'hB, rows[r][5], "waveform");
        end
        bus(1'b1, 4'h1, 32'h0);
        bus(1'b1, 4'h0, 32'h14);
        chk("irq idle", 32'h0, irq);
        lv[1] <= 24'h100000;
        for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk_i);
        chk("irq neg to pos", 32'h1, irq);
        if (irq !== 1'b1) summarize();
        bus(1'b1, 4'h1, 32'h1);
        rc(4'h1, 32'h1, "flag held");
        bus(1'b1, 4'h1, 32'h0);
        rc(4'h1, 32'h0, "flag cleared");
        chk("irq cleared", 32'h0, irq);
        bus(1'b1, 4'h0, 32'h08);
        lv[1] <= 24'hF00000;
        repeat (2000) @(posedge clk_i);
        chk("masked irq", 32'h0, irq);
        rc(4'h1, 32'h1, "flag pos to neg");
        be <= 4'hE;
        bus(1'b1, 4'h1, 32'h0);
        be <= 4'hF;
        rc(4'h1, 32'h1, "flag lane off");
        rc(4'hB, rows[6][5], "waveform held");
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        rc(4'h0, 32'h18, "ctrl after reset");
        rc(4'h1, 32'h0, "flag after reset");
        rc(4'hB, 32'h0, "waveform after reset");
        summarize();
    end
endmodule // vrp_calc_tb
`default_nettype wire
